// file: verilog/ppx_params.svh
// Offsets, field positions, reset values and encodings of the paged register extension.
// Included by ppx_paged_regs only; holds definitions only.
`ifndef PPX_PARAMS_SVH
`define PPX_PARAMS_SVH

// ----------------------------------------------------------------
// Base register holding page and port select
// ----------------------------------------------------------------
`define PPX_SEL_REG_ADDR      4'h7
`define PPX_PAGE_LSB          5
`define PPX_PORT_LSB          0
`define PPX_PAGE_RESET        3'h0
`define PPX_PORT_RESET        4'h0

// ----------------------------------------------------------------
// Paged window and page numbers
// ----------------------------------------------------------------
`define PPX_PAGE_PORT_STATUS  3'h0
`define PPX_PAGE_MAKER_ID     3'h1
`define PPX_PAGE_VENDOR_DEP   3'h7

// ----------------------------------------------------------------
// Paged offsets
// ----------------------------------------------------------------
`define PPX_ADDR_COMPLIANCE   4'h8
`define PPX_ADDR_VSPEC_CTRL   4'h8
`define PPX_ADDR_PORT_EVFLT   4'h9
`define PPX_ADDR_OUI_HIGH     4'hA
`define PPX_ADDR_OUI_MID      4'hB
`define PPX_ADDR_OUI_LOW      4'hC
`define PPX_ADDR_PART_HIGH    4'hD
`define PPX_ADDR_PART_MID     4'hE
`define PPX_ADDR_PART_LOW     4'hF

// ----------------------------------------------------------------
// Field positions (bit 0 is the msb of the byte on the link, so
// position p sits at data bit 7-p; PPX_LSPD_LSB is a plain data bit index)
// ----------------------------------------------------------------
`define PPX_IRQ_EN_BIT        3
`define PPX_FAULT_BIT         4
`define PPX_NPA_BIT           0
`define PPX_LSPD_LSB          0

// ----------------------------------------------------------------
// Reset and constant values
// ----------------------------------------------------------------
`define PPX_COMPLIANCE_VALUE  8'h01
`define PPX_LSPD_RESET        2'h2
`define PPX_LSPD_S100         2'h0
`define PPX_LSPD_S200         2'h1
`define PPX_LSPD_S400         2'h2
`define PPX_LSPD_ILLEGAL      2'h3
`define PPX_PEER_SPEED_S400   2'h2
`define PPX_ACK_BITS          8'h08

`endif

// file: verilog/ppx_pkg.sv
// Types shared by the paged register extension modules.
// Assumes ppx_params.svh is on the include path.
package ppx_pkg;

    // Fault detector states per port
    typedef enum logic [1:0] {
        PPX_PORT_ACTIVE,
        PPX_PORT_RESUMING,
        PPX_PORT_SUSPENDING,
        PPX_PORT_SUSPENDED
    } ppx_port_state_type;

    typedef logic [7:0] ppx_byte_type;

endpackage : ppx_pkg

// file: verilog/ppx_port_if.sv
// Bundle between the register bank and its per-port fault tracker.
// Assumes one clock domain; all signals synchronous to CLK.
interface ppx_port_if #(parameter int NPORTS = 6);
    logic [NPORTS-1:0] resume_req;
    logic [NPORTS-1:0] suspend_req;
    logic [NPORTS-1:0] bias_seen;
    logic [NPORTS-1:0] fault_pulse;
    logic [NPORTS-1:0] suspended;

    modport bank    (output resume_req, output suspend_req, output bias_seen,
                     input fault_pulse, input suspended);
    modport tracker (input resume_req, input suspend_req, input bias_seen,
                     output fault_pulse, output suspended);
endinterface : ppx_port_if

// file: verilog/ppx_fault_tracker.sv
// Per-port resume/suspend sequencer that flags resume and suspend faults.
// Assumes requests and debounced bias are synchronous single-cycle/level inputs.
module ppx_fault_tracker #(
    parameter int NPORTS = 6
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    ppx_port_if.tracker pif
);

    ppx_pkg::ppx_port_state_type state [NPORTS];

    // ----------------------------------------------------------------
    // Per-port sequencing
    // ----------------------------------------------------------------
    // A request is judged on the cycle after it, against the bias level then seen.
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                state[p]           <= ppx_pkg::PPX_PORT_ACTIVE;
                pif.fault_pulse[p] <= 1'b0;
            end
            else
            begin
                pif.fault_pulse[p] <= 1'b0;
                unique case (state[p])
                    ppx_pkg::PPX_PORT_ACTIVE:
                        if (pif.suspend_req[p])
                            state[p] <= ppx_pkg::PPX_PORT_SUSPENDING;
                    ppx_pkg::PPX_PORT_SUSPENDED:
                        if (pif.resume_req[p])
                            state[p] <= ppx_pkg::PPX_PORT_RESUMING;
                    ppx_pkg::PPX_PORT_RESUMING:
                    begin
                        if (pif.bias_seen[p])
                            state[p] <= ppx_pkg::PPX_PORT_ACTIVE;
                        else
                        begin
                            state[p]           <= ppx_pkg::PPX_PORT_SUSPENDED;
                            pif.fault_pulse[p] <= 1'b1;
                        end
                    end
                    ppx_pkg::PPX_PORT_SUSPENDING:
                    begin
                        state[p] <= ppx_pkg::PPX_PORT_SUSPENDED;
                        if (pif.bias_seen[p])
                            pif.fault_pulse[p] <= 1'b1;
                    end
                endcase
            end
        end

        always_comb
        begin
            pif.suspended[p] = (state[p] == ppx_pkg::PPX_PORT_SUSPENDED);
        end
    end

endmodule : ppx_fault_tracker

// file: verilog/ppx_paged_regs.sv
// Paged extended register space of a six-port cable physical layer.
// Assumes the link interface decodes register read/write requests into
// one-cycle strobes with a 4-bit address; bus reset is a separate input.
//
// How it works
// - Enabled event on the port picked by port select sets event flag and notifies link.
// - Hardware reset clears event-enable and fault bits; bus reset does not.
// - Resume or suspend fault sets port fault bit; port stays suspended.
// - Resuming port without incoming bias counts as resume fault.
// - Suspending port still seeing bias counts as suspend fault.
// - Writing 1 clears fault bit; writing 0 leaves it.
// - Page select 1 maps vendor identification page to addresses 8-15.
// - Compliance register always reads 01h.
// - 24-bit maker code read as three bytes, msb at 1010b.
// - 24-bit part code read as three bytes, msb at 1101b.
// - Page select 7 maps vendor-dependent page to addresses 8-15.
// - Flag set: only packets over 8 bits clear fair/priority requests.
// - Flag clear: any non-ack packet clears fair/priority requests.
// - Hardware reset clears null-packet flag; bus reset does not.
// - Link speed codes 00 S100, 01 S200, 10 S400, 11 illegal.
// - Link speed field copied into self-ID speed field.
// - Peers always see S400 capability during self-ID.
// - Hardware reset loads link speed 10b; bus reset does not.
// - Page select in base register 7 picks page for 8-15; resets 0.
// - Port select picks port for per-port fields, numbered from 0.
`include "ppx_params.svh"

module ppx_paged_regs #(
    parameter int          NPORTS    = 6,
    parameter logic [23:0] MAKER_OUI = 24'h5A_A5_01, // Arbitrary value
    parameter logic [23:0] PART_CODE = 24'h3C_C3_02  // Arbitrary value
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              BUS_RESET,
    // Register requests from the link layer controller
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [3:0]        REG_ADDR,
    input  wire logic [7:0]        REG_WDATA,
    output logic      [7:0]        REG_RDATA,
    output logic                   REG_RVALID,
    // Port events and resume/suspend activity
    input  wire logic [NPORTS-1:0] PORT_EVENT,
    input  wire logic [NPORTS-1:0] PORT_RESUME_REQ,
    input  wire logic [NPORTS-1:0] PORT_SUSPEND_REQ,
    input  wire logic [NPORTS-1:0] PORT_BIAS,
    output logic      [NPORTS-1:0] PORT_SUSPENDED,
    output logic                   PORT_EVENT_FLAG,
    output logic                   LINK_NOTIFY,
    // Received packet info for request clearing
    input  wire logic              PKT_END,
    input  wire logic [7:0]        PKT_BITS,
    input  wire logic              FAIR_REQ_SET,
    input  wire logic              PRIO_REQ_SET,
    output logic                   FAIR_REQ_PENDING,
    output logic                   PRIO_REQ_PENDING,
    // Self-ID speed fields and page/port select
    output logic      [1:0]        SELF_ID_SPEED_FIELD,
    output logic      [1:0]        PEER_SPEED_ADVERT,
    output logic      [2:0]        PAGE_SELECT,
    output logic      [3:0]        PORT_SELECT
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [NPORTS-1:0] port_event_irq_enable;
    logic [NPORTS-1:0] port_fault;
    logic              null_packet_keep_requests;
    logic [1:0]        link_speed;
    logic              port_event_flag;
    logic [7:0]        next_rdata;
    logic              port_valid;
    logic [NPORTS-1:0] sel_mask;
    logic              wr_port_page;
    logic              wr_vdep_page;
    logic              clear_requests;

    ppx_port_if #(.NPORTS(NPORTS)) pif ();

    ppx_fault_tracker #(.NPORTS(NPORTS)) u_tracker (
        .clk   (CLK),
        .rst_n (RST_N),
        .pif   (pif.tracker)
    );

    always_comb
    begin
        pif.resume_req  = PORT_RESUME_REQ;
        pif.suspend_req = PORT_SUSPEND_REQ;
        pif.bias_seen   = PORT_BIAS;
    end

    // Byte lane of a field at printed bit position pos
    function automatic int unsigned lane(input int unsigned pos);
        lane = 7 - pos;
    endfunction : lane

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb
    begin
        port_valid   = (PORT_SELECT < 4'(NPORTS));
        sel_mask     = port_valid ? (NPORTS'(1) << PORT_SELECT) : '0;
        wr_port_page = REG_WR && (PAGE_SELECT == `PPX_PAGE_PORT_STATUS)
                       && (REG_ADDR == `PPX_ADDR_PORT_EVFLT);
        wr_vdep_page = REG_WR && (PAGE_SELECT == `PPX_PAGE_VENDOR_DEP)
                       && (REG_ADDR == `PPX_ADDR_VSPEC_CTRL);
    end

    // ----------------------------------------------------------------
    // Page and port select (bus reset leaves them alone)
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PAGE_SELECT <= `PPX_PAGE_RESET;
            PORT_SELECT <= `PPX_PORT_RESET;
        end
        else if (REG_WR && REG_ADDR == `PPX_SEL_REG_ADDR)
        begin
            PAGE_SELECT <= REG_WDATA[`PPX_PAGE_LSB +: 3];
            PORT_SELECT <= REG_WDATA[`PPX_PORT_LSB +: 4];
        end
    end

    // ----------------------------------------------------------------
    // Per-port enable and fault bits
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            port_event_irq_enable <= '0;
        else if (wr_port_page)
        begin
            for (int p = 0; p < NPORTS; p++)
                if (sel_mask[p])
                    port_event_irq_enable[p] <= REG_WDATA[lane(`PPX_IRQ_EN_BIT)];
        end
    end

    // Set from a fault wins over a clearing write in the same cycle
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            port_fault <= '0;
        else
        begin
            for (int p = 0; p < NPORTS; p++)
            begin
                if (pif.fault_pulse[p])
                    port_fault[p] <= 1'b1;
                else if (wr_port_page && sel_mask[p] && REG_WDATA[lane(`PPX_FAULT_BIT)])
                    port_fault[p] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Port event notification
    // ----------------------------------------------------------------
    always_comb
    begin
        port_event_flag = |(PORT_EVENT & port_event_irq_enable & sel_mask);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PORT_EVENT_FLAG <= 1'b0;
            LINK_NOTIFY     <= 1'b0;
        end
        else
        begin
            LINK_NOTIFY <= port_event_flag;
            if (port_event_flag)
                PORT_EVENT_FLAG <= 1'b1;
            else if (BUS_RESET)
                PORT_EVENT_FLAG <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Vendor-dependent control
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            null_packet_keep_requests <= 1'b0;
            link_speed                <= `PPX_LSPD_RESET;
        end
        else if (wr_vdep_page)
        begin
            null_packet_keep_requests <= REG_WDATA[lane(`PPX_NPA_BIT)];
            // Illegal code 11 is refused so the self-ID field never carries it
            if (REG_WDATA[`PPX_LSPD_LSB +: 2] != `PPX_LSPD_ILLEGAL)
                link_speed <= REG_WDATA[`PPX_LSPD_LSB +: 2];
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SELF_ID_SPEED_FIELD <= `PPX_LSPD_RESET;
            PEER_SPEED_ADVERT   <= `PPX_PEER_SPEED_S400;
        end
        else
        begin
            SELF_ID_SPEED_FIELD <= link_speed;
            PEER_SPEED_ADVERT   <= `PPX_PEER_SPEED_S400;
        end
    end

    // ----------------------------------------------------------------
    // Fair and priority request clearing on packet receipt
    // ----------------------------------------------------------------
    always_comb
    begin
        if (null_packet_keep_requests)
            clear_requests = PKT_END && (PKT_BITS > `PPX_ACK_BITS);
        else
            clear_requests = PKT_END && (PKT_BITS != `PPX_ACK_BITS);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            FAIR_REQ_PENDING <= 1'b0;
            PRIO_REQ_PENDING <= 1'b0;
        end
        else
        begin
            // A new request in the clearing cycle stays pending
            if (FAIR_REQ_SET)
                FAIR_REQ_PENDING <= 1'b1;
            else if (clear_requests)
                FAIR_REQ_PENDING <= 1'b0;
            if (PRIO_REQ_SET)
                PRIO_REQ_PENDING <= 1'b1;
            else if (clear_requests)
                PRIO_REQ_PENDING <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        if (REG_ADDR == `PPX_SEL_REG_ADDR)
        begin
            next_rdata[`PPX_PAGE_LSB +: 3] = PAGE_SELECT;
            next_rdata[`PPX_PORT_LSB +: 4] = PORT_SELECT;
        end
        else if (REG_ADDR[3])
        begin
            unique case (PAGE_SELECT)
                `PPX_PAGE_PORT_STATUS:
                    if (REG_ADDR == `PPX_ADDR_PORT_EVFLT && port_valid)
                    begin
                        next_rdata[lane(`PPX_IRQ_EN_BIT)] =
                            |(port_event_irq_enable & sel_mask);
                        next_rdata[lane(`PPX_FAULT_BIT)]  = |(port_fault & sel_mask);
                    end
                `PPX_PAGE_MAKER_ID:
                    unique case (REG_ADDR)
                        `PPX_ADDR_COMPLIANCE: next_rdata = `PPX_COMPLIANCE_VALUE;
                        `PPX_ADDR_OUI_HIGH:   next_rdata = MAKER_OUI[23:16];
                        `PPX_ADDR_OUI_MID:    next_rdata = MAKER_OUI[15:8];
                        `PPX_ADDR_OUI_LOW:    next_rdata = MAKER_OUI[7:0];
                        `PPX_ADDR_PART_HIGH:  next_rdata = PART_CODE[23:16];
                        `PPX_ADDR_PART_MID:   next_rdata = PART_CODE[15:8];
                        `PPX_ADDR_PART_LOW:   next_rdata = PART_CODE[7:0];
                        default:              next_rdata = 8'h00;
                    endcase
                `PPX_PAGE_VENDOR_DEP:
                    if (REG_ADDR == `PPX_ADDR_VSPEC_CTRL)
                    begin
                        next_rdata[lane(`PPX_NPA_BIT)]    = null_packet_keep_requests;
                        next_rdata[`PPX_LSPD_LSB +: 2]    = link_speed;
                    end
                default:
                    next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
                REG_RDATA <= next_rdata;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            PORT_SUSPENDED <= '0;
        else
            PORT_SUSPENDED <= pif.suspended;
    end

endmodule : ppx_paged_regs

// file: verif/ppx_regs_asserts.sv
// Concurrent checks on the ports of the paged register bank.
// Assumes it is bound to ppx_paged_regs; everything runs on CLK.
module ppx_regs_asserts #(
    parameter int          NPORTS    = 6,
    parameter logic [23:0] MAKER_OUI = 24'h00_00_00,
    parameter logic [23:0] PART_CODE = 24'h00_00_00
) (
    // Clock and reset
    input wire logic              CLK,
    input wire logic              RST_N,
    // Register requests
    input wire logic              REG_RD,
    input wire logic [3:0]        REG_ADDR,
    input wire logic [7:0]        REG_RDATA,
    // Port activity
    input wire logic [NPORTS-1:0] PORT_EVENT,
    input wire logic [NPORTS-1:0] PORT_RESUME_REQ,
    input wire logic [NPORTS-1:0] PORT_SUSPEND_REQ,
    input wire logic [NPORTS-1:0] PORT_BIAS,
    input wire logic [NPORTS-1:0] PORT_SUSPENDED,
    input wire logic              PORT_EVENT_FLAG,
    input wire logic              LINK_NOTIFY,
    // Speed and select fields
    input wire logic [1:0]        SELF_ID_SPEED_FIELD,
    input wire logic [1:0]        PEER_SPEED_ADVERT,
    input wire logic [2:0]        PAGE_SELECT,
    input wire logic [3:0]        PORT_SELECT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Selected port saw an event; unimplemented ports never do
    logic sel_ev;
    assign sel_ev = (PORT_SELECT < NPORTS) && PORT_EVENT[PORT_SELECT];

    a_notify_cause:
        assert property (LINK_NOTIFY |-> $past(sel_ev) && PORT_EVENT_FLAG)
        else $error("stray notify");
    a_page_reset:
        assert property ($rose(RST_N) |-> PAGE_SELECT == 3'h0)
        else $error("page select not zero after reset");
    a_compliance_read:
        assert property (REG_RD && PAGE_SELECT == 3'h1 && REG_ADDR == 4'h8 |=> REG_RDATA == 8'h01)
        else $error("compliance byte wrong");
    a_oui_msb:
        assert property (REG_RD && PAGE_SELECT == 3'h1 && REG_ADDR == 4'hA
                         |=> REG_RDATA == MAKER_OUI[23:16])
        else $error("maker code msb wrong");
    a_part_msb:
        assert property (REG_RD && PAGE_SELECT == 3'h1 && REG_ADDR == 4'hD
                         |=> REG_RDATA == PART_CODE[23:16])
        else $error("part code msb wrong");
    a_test_area_zero:
        assert property (REG_RD && PAGE_SELECT == 3'h7 && REG_ADDR > 4'h8 |=> REG_RDATA == 8'h00)
        else $error("reserved location not zero");
    a_speed_legal:
        assert property (SELF_ID_SPEED_FIELD != 2'h3)
        else $error("illegal link speed taken");
    a_peer_s400:
        assert property (PEER_SPEED_ADVERT == 2'h2)
        else $error("peer speed not S400");
    a_resume_fault:
        assert property (PORT_RESUME_REQ[0] ##1 !PORT_BIAS[0] |-> ##[1:3] PORT_SUSPENDED[0])
        else $error("resume fault did not suspend");
    a_suspend_fault:
        assert property (PORT_SUSPEND_REQ[1] ##1 PORT_BIAS[1] |-> ##[1:3] PORT_SUSPENDED[1])
        else $error("suspend fault did not suspend");

    c_notify: cover property (LINK_NOTIFY);
    c_suspended: cover property (PORT_SUSPENDED[1]);
    c_vendor_read: cover property (REG_RD && PAGE_SELECT == 3'h7);
endmodule : ppx_regs_asserts

// file: verif/ppx_llc_model.sv
// Link layer controller model issuing register reads and writes.
// Assumes one-cycle strobes taken on the rising edge; drives on the falling edge.
module ppx_llc_model (
    // Clock
    input  wire logic       clk,
    // Requests
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    // Answer
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end
    // Idle lines are inverted so a late sample never sees the old value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask : rd
endmodule : ppx_llc_model

// file: verif/phy_paged_register_extension_test.sv
// Self-checking bench for the paged register extension.
// Assumes design, partner model and checker are compiled before it.
module phy_paged_register_extension_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] OUI  = 24'h5A_A5_01; // Arbitrary value
    localparam logic [23:0] PART = 24'h3C_C3_02; // Arbitrary value
    logic CLK = 1'b0, RST_N = 1'b0, BUS_RESET = 1'b0, PKT_END = 1'b0;
    logic FAIR_REQ_SET = 1'b0, PRIO_REQ_SET = 1'b0;
    logic REG_WR, REG_RD, REG_RVALID, PORT_EVENT_FLAG, LINK_NOTIFY;
    logic FAIR_REQ_PENDING, PRIO_REQ_PENDING;
    logic [3:0] REG_ADDR, PORT_SELECT;
    logic [7:0] REG_WDATA, REG_RDATA, PKT_BITS = 8'h00, d, v;
    logic [5:0] PORT_EVENT = 6'h00, PORT_RESUME_REQ = 6'h00, PORT_SUSPEND_REQ = 6'h00;
    logic [5:0] PORT_BIAS = 6'h00, PORT_SUSPENDED;
    logic [1:0] SELF_ID_SPEED_FIELD, PEER_SPEED_ADVERT;
    logic [2:0] PAGE_SELECT;
    int failures = 0, samples_checked = 0, cycles = 0, r;

    always #2.5 CLK = ~CLK;

    ppx_paged_regs #(.NPORTS(6), .MAKER_OUI(OUI), .PART_CODE(PART)) u_dut (.*);

    ppx_llc_model u_llc (.clk(CLK), .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_addr(REG_ADDR),
        .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID));

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    // Base register 7 holds page in the top three bits, port in the low four
    task automatic sel(input logic [2:0] pg, input logic [3:0] pt);
        u_llc.wr(4'h7, {pg, 1'b0, pt});
    endtask : sel
    function automatic logic [7:0] id_byte(input logic [3:0] a);
        logic [63:0] pg;
        pg = {8'h01, 8'h00, OUI, PART};
        return pg[8*(15-a) +: 8];
    endfunction : id_byte
    // Ack never clears; with the flag set, short packets keep requests too
    function automatic logic keep_req(input logic f, input logic [7:0] b);
        return f ? (b <= 8'h08) : (b == 8'h08);
    endfunction : keep_req

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        r = $urandom(95545);
        repeat (12) @(posedge CLK);
        @(negedge CLK) RST_N = 1'b1;
        chk({6'h0, SELF_ID_SPEED_FIELD}, 8'h02);
        chk({PAGE_SELECT, 1'b0, PORT_SELECT}, 8'h00);
        sel(3'h7, 4'h0);
        u_llc.rd(4'h8, d);
        chk(d, 8'h02);
        sel(3'h0, 4'h0);
        u_llc.rd(4'h9, d);
        chk(d, 8'h00);
        $display("test reset finished");
        sel(3'h1, 4'h0);
        for (int a = 8; a < 16; a++)
        begin
            u_llc.wr(4'(a), 8'($urandom));
            u_llc.rd(4'(a), d);
            chk(d, id_byte(4'(a)));
        end
        $display("test identification finished");
        sel(3'h7, 4'h0);
        for (int s = 0; s < 4; s++)
        begin
            v = {1'($urandom), 5'h0, 2'(s)};
            u_llc.wr(4'h8, v);
            u_llc.rd(4'h8, d);
            if (s == 3)
                chk(d, {v[7], 7'h02});
            else
                chk(d, v);
            chk({6'h0, SELF_ID_SPEED_FIELD}, {6'h0, d[1:0]});
            chk({6'h0, PEER_SPEED_ADVERT}, 8'h02);
        end
        for (int a = 9; a < 16; a++)
        begin
            u_llc.wr(4'(a), 8'($urandom));
            u_llc.rd(4'(a), d);
            chk(d, 8'h00);
        end
        u_llc.wr(4'h8, 8'h81);
        sel(3'h0, 4'h2);
        u_llc.wr(4'h9, 8'h10);
        @(negedge CLK) BUS_RESET = 1'b1;
        @(negedge CLK) BUS_RESET = 1'b0;
        u_llc.rd(4'h9, d);
        chk(d, 8'h10);
        sel(3'h7, 4'h0);
        u_llc.rd(4'h8, d);
        chk(d, 8'h81);
        $display("test vendor page finished");
        for (int p = 0; p < 7; p++)
        begin
            sel(3'h0, 4'(p));
            v = (p == 1) ? 8'h10 : 8'($urandom) & 8'h10;
            u_llc.wr(4'h9, v);
            @(negedge CLK) BUS_RESET = 1'b1;
            @(negedge CLK) BUS_RESET = 1'b0;
            PORT_EVENT = 6'($urandom) | (6'(p[0]) << p);
            d = {7'h0, (p < 6) && v[4] && PORT_EVENT[p]};
            @(negedge CLK) PORT_EVENT = 6'h00;
            chk({7'h0, LINK_NOTIFY}, d);
            chk({7'h0, PORT_EVENT_FLAG}, d);
        end
        $display("test events finished");
        for (int p = 0; p < 6; p++)
        begin
            sel(3'h0, 4'(p));
            u_llc.wr(4'h9, 8'h10);
            PORT_BIAS = {6{p[0]}};
            PORT_SUSPEND_REQ[p] = 1'b1;
            @(negedge CLK) PORT_SUSPEND_REQ = 6'h00;
            @(negedge CLK) PORT_RESUME_REQ[p] = !p[0];
            @(negedge CLK) PORT_RESUME_REQ = 6'h00;
            repeat (3) @(negedge CLK);
            chk({7'h0, PORT_SUSPENDED[p]}, 8'h01);
            u_llc.rd(4'h9, d);
            chk(d, 8'h18);
            u_llc.wr(4'h9, 8'h10);
            u_llc.rd(4'h9, d);
            chk(d, 8'h18);
            u_llc.wr(4'h9, 8'h18);
            u_llc.rd(4'h9, d);
            chk(d, 8'h10);
        end
        $display("test faults finished");
        sel(3'h7, 4'h0);
        for (int i = 0; i < 12; i++)
        begin
            v = {1'(i / 6), 7'h02};
            u_llc.wr(4'h8, v);
            @(negedge CLK);
            FAIR_REQ_SET = 1'b1;
            PRIO_REQ_SET = 1'b1;
            @(negedge CLK);
            FAIR_REQ_SET = 1'b0;
            PRIO_REQ_SET = 1'b0;
            PKT_END = 1'b1;
            PKT_BITS = (i % 6 < 4) ? 8'(7 + i % 6) : 8'($urandom);
            @(negedge CLK) PKT_END = 1'b0;
            @(negedge CLK);
            chk({6'h0, FAIR_REQ_PENDING, PRIO_REQ_PENDING}, {6'h0, {2{keep_req(v[7], PKT_BITS)}}});
        end
        $display("test packets finished");
        wrap_up();
    end
endmodule : phy_paged_register_extension_test

bind ppx_paged_regs ppx_regs_asserts #(.NPORTS(NPORTS), .MAKER_OUI(MAKER_OUI),
    .PART_CODE(PART_CODE)) u_chk (.*);
